//--- src/card_init_pkg.sv
// package: port map, command bits, reset values and state types for card init logic
package card_init_pkg;

  localparam logic [7:0] PORT_RATE     = 8'h00;
  localparam logic [7:0] PORT_COMMAND  = 8'h02;
  localparam logic [7:0] PORT_MASK     = 8'h03;
  localparam logic [7:0] PORT_PAR_OUT  = 8'h04;
  localparam logic [7:0] PORT_LATCH_A  = 8'h0a;
  localparam logic [7:0] PORT_LATCH_B  = 8'h0b;

  // command register and latch a field positions
  localparam int CMD_RESET_POS    = 0;
  localparam int CMD_ACK_EN_POS   = 3;
  localparam int CMD_LOWEST_POS   = 2;
  localparam int CMD_HIGH_POS     = 4;
  localparam int LATCH_A_MEMDIS_POS = 7;

  localparam logic [7:0] LATCH_RESET   = 8'h00;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0] IREG_RESET    = 8'h00;
  localparam logic [7:0] RREG_RESET    = 8'h00;

  localparam logic [15:0] ONBOARD_TOP  = 16'h23ff;
  localparam logic [15:0] ROM0_TOP     = 16'h07ff;

  localparam logic [7:0] TBE_BIT_MASK  = 8'h10;
  localparam int          TIMER_COUNT  = 5;
  localparam int          LOWEST_SRC   = 7;
  localparam logic [7:0] RST_OPCODE_BASE = 8'hc7;

  // base tick divider (low rate); high rate uses one eighth of it
  localparam int CLK_MHZ        = 100;
  localparam int BASE_TICK_NS   = 1000;
  localparam int BASE_TICK_CYC  = (BASE_TICK_NS * CLK_MHZ) / 1000;
  localparam int HIGH_FACTOR    = 8;

  typedef enum logic [1:0] {
    CPU_HELD  = 2'b00,
    CPU_FETCH = 2'b01
  } cpu_state_t;

  typedef struct packed {
    logic        ints_enabled;
    logic [1:0]  int_mode;
    logic [7:0]  vec_reg;
    logic [7:0]  refresh_reg;
    logic [15:0] pc;
  } cpu_regs_t;

  typedef struct packed {
    logic high_rate_select;
    logic ack_response_enable;
    logic lowest_source_select;
  } cmd_opts_t;

  typedef struct packed {
    logic receive_ready_flag;
    logic start_detected_flag;
    logic overrun_flag;
    logic framing_flag;
  } rx_status_t;

endpackage : card_init_pkg

//--- src/card_reset_initialization.sv
// card reset and controller initialization logic
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - reset clears cpu vector, refresh, mode, pc
// - after reset fetching starts at address zero
// - reset clears both card output latches
// - reset forces on-board memory enabled
// - first rom decodes lowest 2 KB, enabled
// - controller not reset; software must initialize it
// - high-rate bit scales serial and timer rates
// - ack enable selects restart opcode or none
// - command bit picks aux input or timer five
// - command reset clears rx flags, line high
// - command reset: only transmit-empty pending, timers expire
// - mask port holds one bit per source
// - mask zero masks all eight sources
// - parallel output port survives reset
// - latch a bit seven disables memory if fitted
// - command 09h enables ack and resets
// - rate c0h low-rate gives 9600, one stop
// - rate 90h with command 11h gives 19200
module card_reset_initialization
  import card_init_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        io_write,
  input  wire logic [7:0]  io_port,
  input  wire logic [7:0]  io_data,
  input  wire logic [15:0] mem_addr,
  input  wire logic        interrupt_ack_cycle,
  input  wire logic        aux_interrupt_input,
  input  wire logic        memory_disable_fitted,
  input  wire logic [7:0]  raw_requests,
  input  wire logic [4:0]  timer_expire,
  output var  logic        cpu_running,
  output var  logic [15:0] cpu_pc,
  output var  logic        cpu_ints_enabled,
  output var  logic [1:0]  cpu_int_mode,
  output var  logic [7:0]  cpu_vec_reg,
  output var  logic [7:0]  cpu_refresh_reg,
  output var  logic [7:0]  latch_a,
  output var  logic [7:0]  latch_b,
  output var  logic        onboard_mem_enable,
  output var  logic        rom0_select,
  output var  logic [7:0]  rate_select,
  output var  logic [7:0]  source_mask,
  output var  logic [7:0]  par_out,
  output var  logic        high_rate_select,
  output var  logic        ack_response_enable,
  output var  logic        lowest_source_select,
  output var  logic        serial_tx,
  output var  logic [3:0]  rx_status,
  output var  logic [7:0]  pending_requests,
  output var  logic [4:0]  timers_expired,
  output var  logic        rate_tick,
  output var  logic        ack_drive,
  output var  logic [7:0]  ack_opcode,
  output var  logic        interrupt_out
);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic wr_to(input logic we, input logic [7:0] p, input logic [7:0] tgt);
    return we && (p == tgt);
  endfunction : wr_to

  logic       cmd_wr;
  logic       cmd_reset;
  logic [7:0] gated;
  logic [2:0] top_src;
  logic       any_req;
  logic       rst_sync1_r;
  logic       rst_sync2_r;
  cpu_state_t state_r;
  cpu_regs_t  regs_r;

  assign cmd_wr    = wr_to(io_write, io_port, PORT_COMMAND);
  assign cmd_reset = cmd_wr && io_data[CMD_RESET_POS];

  // reset release synchronised to clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // processor reset state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CPU_HELD;
      regs_r  <= '{1'b0, 2'd0, IREG_RESET, RREG_RESET, PC_RESET};
    end else if (!rst_sync2_r) begin
      state_r <= CPU_HELD;
      regs_r  <= '{1'b0, 2'd0, IREG_RESET, RREG_RESET, PC_RESET};
    end else begin
      unique case (state_r)
        CPU_HELD:  state_r <= CPU_FETCH;
        CPU_FETCH: state_r <= CPU_FETCH;
        default:   state_r <= CPU_HELD;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_running      <= 1'b0;
      cpu_pc           <= PC_RESET;
      cpu_ints_enabled <= 1'b0;
      cpu_int_mode     <= 2'd0;
      cpu_vec_reg      <= IREG_RESET;
      cpu_refresh_reg  <= RREG_RESET;
    end else begin
      cpu_running      <= (state_r == CPU_FETCH);
      cpu_pc           <= regs_r.pc;
      cpu_ints_enabled <= regs_r.ints_enabled;
      cpu_int_mode     <= regs_r.int_mode;
      cpu_vec_reg      <= regs_r.vec_reg;
      cpu_refresh_reg  <= regs_r.refresh_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // card latches and memory enable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_a <= LATCH_RESET;
      latch_b <= LATCH_RESET;
    end else if (!rst_sync2_r) begin
      latch_a <= LATCH_RESET;
      latch_b <= LATCH_RESET;
    end else begin
      if (wr_to(io_write, io_port, PORT_LATCH_A))
        latch_a <= io_data;
      if (wr_to(io_write, io_port, PORT_LATCH_B))
        latch_b <= io_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      onboard_mem_enable <= 1'b1;
      rom0_select        <= 1'b0;
    end else begin
      onboard_mem_enable <= !rst_sync2_r || !(memory_disable_fitted
                            && latch_a[LATCH_A_MEMDIS_POS]);
      rom0_select        <= (mem_addr <= ROM0_TOP)
                            && (!rst_sync2_r || !(memory_disable_fitted
                            && latch_a[LATCH_A_MEMDIS_POS]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // controller ports: no reset, power-up contents are whatever the flops hold
  always_ff @(posedge clock) begin
    if (wr_to(io_write, io_port, PORT_RATE))
      rate_select <= io_data;
    if (wr_to(io_write, io_port, PORT_MASK))
      source_mask <= io_data;
    if (wr_to(io_write, io_port, PORT_PAR_OUT))
      par_out <= io_data;
    if (cmd_wr) begin
      high_rate_select     <= io_data[CMD_HIGH_POS];
      ack_response_enable  <= io_data[CMD_ACK_EN_POS];
      lowest_source_select <= io_data[CMD_LOWEST_POS];
    end
  end

  // receiver status and transmit line
  always_ff @(posedge clock) begin
    if (cmd_reset) begin
      rx_status <= 4'h0;
      serial_tx <= 1'b1;
    end
  end

  // pending requests; set wins only outside a command reset
  always_ff @(posedge clock) begin
    if (cmd_reset) begin
      pending_requests <= TBE_BIT_MASK;
      timers_expired   <= '1;
    end else begin
      pending_requests[LOWEST_SRC-1:0] <= pending_requests[LOWEST_SRC-1:0]
                                          | raw_requests[LOWEST_SRC-1:0];
      pending_requests[LOWEST_SRC] <= pending_requests[LOWEST_SRC]
        | (lowest_source_select ? aux_interrupt_input : timer_expire[4]);
      timers_expired   <= timers_expired | timer_expire;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rate tick: divider shortened by high-rate bit for serial and timers
  logic [7:0] div_cnt_r;
  logic [7:0] div_top;
  assign div_top = high_rate_select ? 8'((BASE_TICK_CYC / HIGH_FACTOR) - 1)
                                    : 8'(BASE_TICK_CYC - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= 8'h00;
      rate_tick <= 1'b0;
    end else if (div_cnt_r >= div_top) begin
      div_cnt_r <= 8'h00;
      rate_tick <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      rate_tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt priority and acknowledge answer
  assign gated = pending_requests & source_mask;
  assign any_req = |gated;
  always_comb begin
    top_src = 3'd0;
    for (int i = 0; i < 8; i++)
      if (gated[i] && top_src == 3'd0 && !gated[0])
        top_src = 3'(i);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_drive     <= 1'b0;
      ack_opcode    <= 8'h00;
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= any_req;
      ack_drive     <= interrupt_ack_cycle && ack_response_enable;
      ack_opcode    <= RST_OPCODE_BASE | {2'b00, top_src, 3'b000};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_latch_clear;
    @(posedge clock) $rose(rst_n) |-> (latch_a == LATCH_RESET && latch_b == LATCH_RESET);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_mem_on;
    @(posedge clock) disable iff (!rst_n) !rst_sync2_r |=> onboard_mem_enable;
  endproperty
  a_mem_on: assert property (p_mem_on) else $error("memory not enabled in reset");

  property p_fetch;
    @(posedge clock) disable iff (!rst_n) $rose(rst_sync2_r) |-> ##2 cpu_running && cpu_pc == 16'h0000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not started at zero");

  property p_cpu_clear;
    @(posedge clock) disable iff (!rst_n) !cpu_running |-> (cpu_int_mode == 2'd0 && !cpu_ints_enabled);
  endproperty
  a_cpu_clear: assert property (p_cpu_clear) else $error("cpu state not clear");

  property p_cmd_reset;
    @(posedge clock) disable iff (!rst_n) cmd_reset |=> pending_requests == TBE_BIT_MASK && serial_tx && rx_status == 4'h0;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset) else $error("command reset wrong");

  property p_timers;
    @(posedge clock) disable iff (!rst_n) cmd_reset |=> &timers_expired && !pending_requests[7];
  endproperty
  a_timers: assert property (p_timers) else $error("timers not expired");

  property p_mask_zero;
    @(posedge clock) disable iff (!rst_n) (source_mask == 8'h00) |=> !interrupt_out;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked source leaked");

  property p_ack;
    @(posedge clock) disable iff (!rst_n) (interrupt_ack_cycle && !ack_response_enable) |=> !ack_drive;
  endproperty
  a_ack: assert property (p_ack) else $error("ack answered when off");

  property p_memdis;
    @(posedge clock) disable iff (!rst_n) (rst_sync2_r && memory_disable_fitted && latch_a[7]) |=> !onboard_mem_enable;
  endproperty
  a_memdis: assert property (p_memdis) else $error("memory not disabled");

  property p_rom0;
    @(posedge clock) disable iff (!rst_n) (!rst_sync2_r && mem_addr <= ROM0_TOP) |=> rom0_select;
  endproperty
  a_rom0: assert property (p_rom0) else $error("first rom not selected in reset");

  property p_latch_hold;
    @(posedge clock) disable iff (!rst_n) !rst_sync2_r |=> (latch_a == LATCH_RESET && latch_b == LATCH_RESET);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch not held in reset");

  c_cmd_09: cover property (@(posedge clock) cmd_wr && io_data == 8'h09);
  c_cmd_11: cover property (@(posedge clock) cmd_wr && io_data == 8'h11);
  c_ack:    cover property (@(posedge clock) ack_drive);
  c_memdis: cover property (@(posedge clock) !onboard_mem_enable);

endmodule : card_reset_initialization

`default_nettype wire

//--- test/cpu_model.sv
// processor and bus reset source model driving the card's write port
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic       clock,
  output var  logic       rst_n,
  output var  logic       io_write,
  output var  logic [7:0] io_port,
  output var  logic [7:0] io_data
);
  initial begin
    rst_n    = 1'b0;
    io_write = 1'b0;
    io_port  = 8'hff;
    io_data  = 8'hff;
  end
  task automatic reset_set(input logic level);
    @(negedge clock);
    rst_n = level;
  endtask : reset_set
  // one write per call; released bus shows inverted values
  task automatic io_out(input logic [7:0] port, input logic [7:0] data);
    @(negedge clock);
    io_port  = port;
    io_data  = data;
    io_write = 1'b1;
    @(negedge clock);
    io_write = 1'b0;
    io_port  = ~port;
    io_data  = ~data;
  endtask : io_out
endmodule : cpu_model
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for card reset and controller initialization
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import card_init_pkg::*;
;
  logic        clock, rst_n, io_write, ack_cyc, aux_in, mem_dis_fit;
  logic [7:0]  io_port, io_data, raw_req;
  logic [15:0] mem_addr, cpu_pc;
  logic [4:0]  tmr_exp, tmr_done;
  logic        running, ie, mem_en, rom0, hi_rate, ack_en, low_sel, tx, tick, ack_drv, irq;
  logic [1:0]  imode;
  logic [7:0]  vreg, rreg, lat_a, lat_b, rate, mask, par, pend, ack_op;
  logic [3:0]  rx_st;
  int          err_count, cmp_count;

  cpu_model cpu (.clock(clock), .rst_n(rst_n), .io_write(io_write), .io_port(io_port),
    .io_data(io_data));
  card_reset_initialization DUT (.clock(clock), .rst_n(rst_n), .io_write(io_write),
    .io_port(io_port), .io_data(io_data), .mem_addr(mem_addr), .interrupt_ack_cycle(ack_cyc),
    .aux_interrupt_input(aux_in), .memory_disable_fitted(mem_dis_fit), .raw_requests(raw_req),
    .timer_expire(tmr_exp), .cpu_running(running), .cpu_pc(cpu_pc), .cpu_ints_enabled(ie),
    .cpu_int_mode(imode), .cpu_vec_reg(vreg), .cpu_refresh_reg(rreg), .latch_a(lat_a),
    .latch_b(lat_b), .onboard_mem_enable(mem_en), .rom0_select(rom0), .rate_select(rate),
    .source_mask(mask), .par_out(par), .high_rate_select(hi_rate),
    .ack_response_enable(ack_en), .lowest_source_select(low_sel), .serial_tx(tx),
    .rx_status(rx_st), .pending_requests(pend), .timers_expired(tmr_done), .rate_tick(tick),
    .ack_drive(ack_drv), .ack_opcode(ack_op), .interrupt_out(irq));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_run();
    for (int i = 0; i < 12 && running !== 1'b1; i++) @(negedge clock);
    check("running", running, 1);
  endtask : wait_run
  task automatic tick_gap(input logic [15:0] exp);
    int gap;
    for (int i = 0; i < 300 && tick !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    gap = 1;
    for (int i = 0; i < 300 && tick !== 1'b1; i++) begin
      @(negedge clock);
      gap++;
    end
    check("tick_gap", gap[15:0], exp);
  endtask : tick_gap
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_start();
    check("lat_a", lat_a, LATCH_RESET);
    check("lat_b", lat_b, LATCH_RESET);
    check("mem_en", mem_en, 1);
    check("ie_mode", {ie, imode}, 0);
    check("vec_ref", {vreg, rreg}, {IREG_RESET, RREG_RESET});
    check("pc", cpu_pc, PC_RESET);
    cpu.reset_set(1'b1);
    @(negedge clock);
    check("run_early", running, 0);
    wait_run();
    repeat (2) @(negedge clock);
    check("rom0_in", rom0, 1);
    mem_addr = ROM0_TOP + 16'h0001;
    repeat (2) @(negedge clock);
    check("rom0_out", rom0, 0);
  endtask : t_start
  task automatic t_cmd();
    cpu.io_out(PORT_COMMAND, 8'h09);
    @(negedge clock);
    check("ack_en", ack_en, 1);
    check("hi_rate", hi_rate, 0);
    check("pend", pend, TBE_BIT_MASK);
    check("tmr_done", tmr_done, 5'h1f);
    check("tx", tx, 1);
    check("rx_st", rx_st, 0);
  endtask : t_cmd
  task automatic t_rates();
    cpu.io_out(PORT_RATE, 8'hc0);
    cpu.io_out(PORT_COMMAND, 8'h01);
    @(negedge clock);
    check("rate", rate, 8'hc0);
    tick_gap(BASE_TICK_CYC);
    cpu.io_out(PORT_RATE, 8'h90);
    cpu.io_out(PORT_COMMAND, 8'h11);
    @(negedge clock);
    check("rate", rate, 8'h90);
    check("hi_rate", hi_rate, 1);
    tick_gap(BASE_TICK_CYC / HIGH_FACTOR);
  endtask : t_rates
  task automatic t_mask();
    cpu.io_out(PORT_MASK, 8'h00);
    repeat (2) @(negedge clock);
    check("mask", mask, 8'h00);
    check("irq_none", irq, 0);
    cpu.io_out(PORT_MASK, TBE_BIT_MASK);
    repeat (2) @(negedge clock);
    check("irq_tbe", irq, 1);
    cpu.io_out(PORT_MASK, ~TBE_BIT_MASK);
    repeat (2) @(negedge clock);
    check("irq_other", irq, 0);
  endtask : t_mask
  task automatic t_ack();
    logic seen;
    cpu.io_out(PORT_COMMAND, 8'h01);
    cpu.io_out(PORT_MASK, TBE_BIT_MASK);
    seen = 1'b0;
    ack_cyc = 1'b1;
    repeat (6) begin
      @(negedge clock);
      seen = seen | ack_drv;
    end
    ack_cyc = 1'b0;
    check("ack_off", seen, 0);
    cpu.io_out(PORT_COMMAND, 8'h09);
    ack_cyc = 1'b1;
    for (int i = 0; i < 8 && ack_drv !== 1'b1; i++) @(negedge clock);
    check("ack_on", ack_drv, 1);
    check("ack_op", ack_op, RST_OPCODE_BASE | 8'h20);
    ack_cyc = 1'b0;
  endtask : t_ack
  task automatic t_lowest();
    cpu.io_out(PORT_COMMAND, 8'h05);
    check("low_sel", low_sel, 1);
    aux_in = 1'b1;
    for (int i = 0; i < 8 && pend[LOWEST_SRC] !== 1'b1; i++) @(negedge clock);
    check("aux_req", pend[LOWEST_SRC], 1);
    aux_in = 1'b0;
    cpu.io_out(PORT_COMMAND, 8'h01);
    aux_in = 1'b1;
    repeat (4) @(negedge clock);
    check("aux_ign", pend[LOWEST_SRC], 0);
    aux_in = 1'b0;
    tmr_exp = 5'h10;
    @(negedge clock);
    tmr_exp = 5'h00;
    for (int i = 0; i < 8 && pend[LOWEST_SRC] !== 1'b1; i++) @(negedge clock);
    check("tmr5_req", pend[LOWEST_SRC], 1);
  endtask : t_lowest
  task automatic t_latch();
    cpu.io_out(PORT_PAR_OUT, 8'h5a);
    cpu.io_out(PORT_LATCH_B, 8'h3c);
    cpu.io_out(PORT_LATCH_A, 8'h80);
    cpu.io_out(8'h05, 8'hff);
    repeat (2) @(negedge clock);
    check("par", par, 8'h5a);
    check("lat_b", lat_b, 8'h3c);
    check("mem_keep", mem_en, 1);
    mem_dis_fit = 1'b1;
    repeat (2) @(negedge clock);
    check("mem_dis", mem_en, 0);
    cpu.reset_set(1'b0);
    @(negedge clock);
    check("lat_a", lat_a, LATCH_RESET);
    check("lat_b", lat_b, LATCH_RESET);
    check("mem_on", mem_en, 1);
    check("par_kept", par, 8'h5a);
    repeat (3) @(negedge clock);
    cpu.reset_set(1'b1);
    wait_run();
    check("lat_a_hold", lat_a, LATCH_RESET);
    check("mem_hold", mem_en, 1);
  endtask : t_latch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #900000;
    err_count++;
    end_of_test();
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    mem_addr = ROM0_TOP;
    ack_cyc = 1'b0;
    aux_in = 1'b0;
    mem_dis_fit = 1'b0;
    raw_req = 8'h00;
    tmr_exp = 5'h00;
    repeat (6) @(negedge clock);
    t_start();
    t_cmd();
    t_rates();
    t_mask();
    t_ack();
    t_lowest();
    t_latch();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
